// ===== src/slot_pkg.sv
/*
  Constants for the single-wire slave: clock rate, slot timing, states.
  Assumes a 100 MHz system clock; the line is sampled synchronously.
*/
package slot_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 4;
  // Times in microseconds, as printed or chosen inside the allowed range
  localparam int T_RESET_MIN_US = 480;
  localparam int T_PRES_WAIT_US = 30;
  localparam int T_PRES_LOW_US = 120;
  localparam int T_WR_SAMPLE_US = 30;
  localparam int T_RD_VALID_US = 15;
  // Cycle counts derived from the times
  localparam int RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
  localparam int PRES_LOW_CYC = T_PRES_LOW_US * CLK_MHZ;
  localparam logic [CNT_W-1:0] PRES_WAIT_CYC = CNT_W'(T_PRES_WAIT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] WR_SAMPLE_CYC = CNT_W'(T_WR_SAMPLE_US * CLK_MHZ);
  // Compare one cycle early so the registered release ends the drive exactly at the end of the valid window
  localparam logic [CNT_W-1:0] RD_HOLD_CYC = CNT_W'(T_RD_VALID_US * CLK_MHZ - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [BIT_CNT_W-1:0] BITS_NONE = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BITS_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BITS_LAST = 4'h7;
  localparam logic [BIT_CNT_W-1:0] BITS_STEP = 4'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RST_LOW = 5'b0_0010,
    ST_PRES_WAIT = 5'b0_0100,
    ST_PRES_DRIVE = 5'b0_1000,
    ST_SLOT = 5'b1_0000
  } slave_state_t;
endpackage : slot_pkg

// ===== src/line_if.sv
/*
  Carrier for line events from the edge watcher to the slave sequencer.
  Assumes both ends run on the same clock.
*/
interface line_if;
  logic fall;
  logic rise;
  logic long_low;
  modport src (output fall, output rise, output long_low);
  modport dst (input fall, input rise, input long_low);
endinterface : line_if

// ===== src/line_watch.sv
/*
  Edge and long-low detector for the shared open-drain line.
  Assumes dq_in is already synchronous to clk.
*/
module line_watch
  import slot_pkg::*;
#(
  parameter int RESET_CYC = RESET_MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line level
  input wire logic dq_in,
  // Events
  line_if.src ev
);
  localparam logic [CNT_W-1:0] RESET_LIM = CNT_W'(RESET_CYC - 1);

  logic dq_q;
  logic [CNT_W-1:0] low_cnt;

  wire at_limit = (low_cnt == RESET_LIM);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_q <= 1'b1;
      low_cnt <= CNT_ZERO;
    end else begin
      dq_q <= dq_in;
      // Saturate so a stuck-low line never wraps into a false short pulse
      if (dq_in) begin
        low_cnt <= CNT_ZERO;
      end else if (!at_limit) begin
        low_cnt <= low_cnt + CNT_ONE;
      end
    end
  end

  assign ev.fall = dq_q & ~dq_in;
  assign ev.rise = ~dq_q & dq_in;
  assign ev.long_low = at_limit & ~dq_in;
endmodule : line_watch

// ===== src/slot_slave.sv
/*
  Slave end of the single-wire link: reset/presence, write and read slots.
  Assumes an external pull-up; dq_in is synchronous to clk. The user side
  decides which slots are read slots by loading bytes or raising status_mode.
*/
// Overview of operation
// - Master starts all signals; slave only presence.
// - After reset rise wait, then presence low.
// - Slave samples write slot between 15-60 us.
// - Slave sends data only inside read slots.
// - Slave drives zero, releases after it.
// - Read data valid 15 us after fall.
// - Bytes travel least significant bit first.
// - Commands are eight write slots each.
// - Status polls answer zero busy, one done.
module slot_slave
  import slot_pkg::*;
#(
  parameter int RESET_CYC = RESET_MIN_CYC,
  parameter int PRES_CYC = PRES_LOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Open-drain line
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  // Received bytes
  output logic [BYTE_W-1:0] rx_byte,
  output logic rx_valid,
  // Bytes to send in read slots
  input wire logic [BYTE_W-1:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  // Completion polling
  input wire logic status_mode,
  input wire logic op_busy,
  // Link events
  output logic bus_reset,
  output logic presence_done
);
  localparam logic [CNT_W-1:0] PRES_LIM = CNT_W'(PRES_CYC);

  line_if ev ();

  line_watch #(.RESET_CYC(RESET_CYC)) u_watch (
    .clk(clk),
    .rst_n(rst_n),
    .dq_in(dq_in),
    .ev(ev)
  );

  slave_state_t state;
  slave_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic slot_is_read;
  logic [BYTE_W-1:0] tx_sh;
  logic [BIT_CNT_W-1:0] tx_left;
  logic [BYTE_W-1:0] rx_sh;
  logic [BIT_CNT_W-1:0] rx_cnt;

  // Decode
  wire in_idle = (state == ST_IDLE);
  wire in_slot = (state == ST_SLOT);
  wire slot_start = in_idle & ev.fall;
  wire have_tx = (tx_left != BITS_NONE);
  wire start_read = slot_start & (have_tx | status_mode);
  wire read_bit = have_tx ? tx_sh[0] : ~op_busy;
  wire pres_wait_end = (state == ST_PRES_WAIT) & (cnt == PRES_WAIT_CYC);
  wire pres_end = (state == ST_PRES_DRIVE) & (cnt == PRES_LIM);
  wire wr_sample = in_slot & ~slot_is_read & (cnt == WR_SAMPLE_CYC);
  wire rd_release = in_slot & slot_is_read & (cnt == RD_HOLD_CYC);
  wire rx_last = (rx_cnt == BITS_LAST);
  wire load_tx = tx_ready & tx_valid;
  wire slot_done = in_slot & dq_in & (slot_is_read ? (cnt > RD_HOLD_CYC) : (cnt > WR_SAMPLE_CYC));

  always_comb begin
    next_state = state;
    next_cnt = cnt + CNT_ONE;
    case (state)
      ST_IDLE: begin
        next_cnt = CNT_ZERO;
        if (ev.fall) begin
          next_state = ST_SLOT;
        end
      end
      ST_RST_LOW: begin
        next_cnt = CNT_ZERO;
        if (ev.rise) begin
          next_state = ST_PRES_WAIT;
        end
      end
      ST_PRES_WAIT: begin
        if (pres_wait_end) begin
          next_state = ST_PRES_DRIVE;
          next_cnt = CNT_ZERO;
        end
      end
      ST_PRES_DRIVE: begin
        if (pres_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_SLOT: begin
        // Wait for the line to come back high before arming the next slot
        if (slot_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = CNT_ZERO;
      end
    endcase
    // Any low past the reset minimum wins over everything else
    if (ev.long_low) begin
      next_state = ST_RST_LOW;
      next_cnt = CNT_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      slot_is_read <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (slot_start) begin
        slot_is_read <= start_read;
      end
    end
  end

  // Line drive: only ever low or released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= 1'b0;
      dq_oe <= 1'b0;
    end else begin
      dq_out <= 1'b0;
      if (ev.long_low) begin
        dq_oe <= 1'b0;
      end else if (pres_wait_end) begin
        dq_oe <= 1'b1;
      end else if (pres_end) begin
        dq_oe <= 1'b0;
      end else if (start_read & ~read_bit) begin
        dq_oe <= 1'b1;
      end else if (rd_release) begin
        dq_oe <= 1'b0;
      end
    end
  end

  // Transmit shifter; a reset drops any unsent bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh <= '0;
      tx_left <= BITS_NONE;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ~have_tx & ~load_tx & ~ev.long_low;
      if (ev.long_low) begin
        tx_left <= BITS_NONE;
      end else if (load_tx) begin
        tx_sh <= tx_byte;
        tx_left <= BITS_BYTE;
      end else if (start_read & have_tx) begin
        tx_sh <= {1'b0, tx_sh[BYTE_W-1:1]};
        tx_left <= tx_left - BITS_STEP;
      end
    end
  end

  // Receive shifter, LSB first, eight slots per byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh <= '0;
      rx_cnt <= BITS_NONE;
      rx_byte <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= wr_sample & rx_last;
      if (ev.long_low) begin
        rx_cnt <= BITS_NONE;
      end else if (wr_sample) begin
        rx_sh <= {dq_in, rx_sh[BYTE_W-1:1]};
        rx_cnt <= rx_last ? BITS_NONE : rx_cnt + BITS_STEP;
        if (rx_last) begin
          rx_byte <= {dq_in, rx_sh[BYTE_W-1:1]};
        end
      end
    end
  end

  // Link event pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reset <= 1'b0;
      presence_done <= 1'b0;
    end else begin
      bus_reset <= ev.long_low & (state != ST_RST_LOW);
      presence_done <= pres_end;
    end
  end
endmodule : slot_slave

// ===== verif/slot_slave_props.sv
/*
  Port checker for slot_slave.
  Assumes one clock domain and the asynchronous active-low reset.
*/
module slot_slave_props
  import slot_pkg::*;
#(
  parameter int RESET_CYC = RESET_MIN_CYC,
  parameter int PRES_CYC = PRES_LOW_CYC
) (
  // Design ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire logic [BYTE_W-1:0] rx_byte,
  input wire logic rx_valid,
  input wire logic [BYTE_W-1:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic status_mode,
  input wire logic op_busy,
  input wire logic bus_reset,
  input wire logic presence_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [CNT_W-1:0] oe_run;
  logic [CNT_W-1:0] low_run;
  // Run lengths of slave drive and of low line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_run <= CNT_ZERO;
      low_run <= CNT_ZERO;
    end else begin
      oe_run <= dq_oe ? oe_run + CNT_ONE : CNT_ZERO;
      low_run <= dq_in ? CNT_ZERO : low_run + CNT_ONE;
    end
  end
  AST_DRIVE_LOW: assert property (dq_oe |-> !dq_out)
    else $error("slave drives the line high");
  AST_PRES_LEN: assert property (presence_done |-> oe_run == CNT_W'(PRES_CYC + 1))
    else $error("presence pulse length wrong");
  // Drive spans the full valid window: set on the fall edge, dropped on the edge after the limit
  AST_READ_HOLD: assert property ($fell(dq_oe) && !presence_done |->
    oe_run == CNT_W'(T_RD_VALID_US * CLK_MHZ))
    else $error("read zero hold wrong");
  AST_BUS_RESET: assert property (low_run == CNT_W'(RESET_CYC) |-> ##[0:3] bus_reset)
    else $error("long low not taken as reset");
  AST_RESET_QUIET: assert property (bus_reset |-> !dq_oe)
    else $error("slave drives during reset");
  AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
  AST_TX_READY: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("tx_ready stays high after load");
  AST_STATUS_DRIVE: assert property ($rose(dq_oe) && !$past(dq_in) && tx_ready |->
    status_mode && op_busy)
    else $error("slave drives outside a read slot");
  cover property (presence_done);
  cover property (bus_reset);
  cover property (rx_valid);
  cover property ($fell(dq_oe) && !presence_done);
endmodule : slot_slave_props

// ===== verif/line_master.sv
/*
  Bus master model: reset pulse and time slots on the line.
  Assumes the bench resolves the line with a pull-up.
*/
module line_master (
  // Clock and line
  input wire logic clk,
  input wire logic dq,
  // Pull-low enable
  output logic m_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Master only pulls low or releases
  initial m_oe = 1'b0;
  task automatic reset_bus(input int low_cyc, output int seen);
    seen = 0;
    m_oe <= 1'b1;
    repeat (low_cyc) @(posedge clk);
    m_oe <= 1'b0;
    repeat (3300) begin
      @(posedge clk);
      #1 seen += int'(!dq);
    end
    @(posedge clk);
  endtask : reset_bus
  // Short low writes a one or opens a read
  task automatic slot(input logic b, output logic r);
    m_oe <= 1'b1;
    repeat (b ? 200 : 6000) @(posedge clk);
    m_oe <= 1'b0;
    repeat (b ? 1100 : 100) @(posedge clk);
    #1 r = dq;
    repeat (b ? 4801 : 1) @(posedge clk);
  endtask : slot
endmodule : line_master

// ===== verif/tb_slot_slave.sv
/*
  Testbench for slot_slave with a master model on the line.
  Assumes a pull-up: the line is low while either side drives.
*/
module tb_slot_slave
  import slot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Reset threshold must exceed a write-zero low
  localparam int RST_C = 6500;
  localparam int PRES_C = 100;
  // Eighteen slots of 61 us and one reset, with margin
  localparam int RUN_CYC = 130000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_valid = 1'b0;
  logic status_mode = 1'b0;
  logic op_busy = 1'b0;
  logic [BYTE_W-1:0] tx_byte = 8'h00;
  logic dq, dq_out, dq_oe, m_oe, rx_valid, tx_ready, bus_reset, presence_done, r;
  logic [BYTE_W-1:0] rx_byte, rx_cap, v, got;
  int fails = 0;
  int check_count = 0;
  int rx_n = 0;
  int pres_n = 0;
  int bus_n = 0;
  int n;
  assign dq = ~((dq_oe & ~dq_out) | m_oe);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rx_cap <= rx_byte;
      rx_n <= rx_n + 1;
    end
    if (presence_done === 1'b1) pres_n <= pres_n + 1;
    if (bus_reset === 1'b1) bus_n <= bus_n + 1;
  end
  slot_slave #(.RESET_CYC(RST_C), .PRES_CYC(PRES_C)) u_slot_slave (.clk(clk), .rst_n(rst_n),
    .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .status_mode(status_mode),
    .op_busy(op_busy), .bus_reset(bus_reset), .presence_done(presence_done));
  line_master u_line_master (.clk(clk), .dq(dq), .m_oe(m_oe));
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  // Expected poll answer: zero while busy, one when done
  function automatic logic exp_poll(input logic busy);
    return ~busy;
  endfunction : exp_poll
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (RUN_CYC) @(posedge clk);
    $display("ERROR %0t watchdog expired", $time);
    fails++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hcbb2));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // A byte loaded before a bus reset must be dropped by it
    v = 8'($urandom);
    tx_byte <= v;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    u_line_master.reset_bus(RST_C + 100, n);
    chk(16'(n), 16'(PRES_C + 1), "presence low");
    chk(16'(pres_n), 16'h0001, "presence pulse");
    chk(16'(bus_n), 16'h0001, "bus reset pulse");
    chk({15'h0000, tx_ready}, 16'h0001, "tx dropped by reset");
    $display("test reset done");
    v = 8'($urandom);
    for (int i = 0; i < 8; i++) u_line_master.slot(v[i], r);
    chk({8'h00, rx_cap}, {8'h00, v}, "write byte");
    chk(16'(rx_n), 16'h0001, "rx count");
    $display("test write done");
    v = 8'($urandom);
    tx_byte <= v;
    tx_valid <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_line_master.slot(1'b1, r);
      got[i] = r;
    end
    chk({8'h00, got}, {8'h00, v}, "read byte");
    chk(16'(rx_n), 16'h0001, "read not received");
    chk({15'h0000, tx_ready}, 16'h0001, "tx ready after byte");
    $display("test read done");
    status_mode <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      op_busy <= (i == 0);
      u_line_master.slot(1'b1, r);
      chk({15'h0000, r}, {15'h0000, exp_poll(i == 0)}, "status poll");
    end
    $display("test status done");
    report_and_stop();
  end
endmodule : tb_slot_slave
bind slot_slave slot_slave_props #(.RESET_CYC(RESET_CYC), .PRES_CYC(PRES_CYC))
  u_slot_slave_props (.clk(clk), .rst_n(rst_n), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .status_mode(status_mode),
  .op_busy(op_busy), .bus_reset(bus_reset), .presence_done(presence_done));
